// ===== pkg/scm_map.svh
// offsets, field positions, reset values and counts for the stepper channel monitor
`ifndef SCM_MAP_SVH
`define SCM_MAP_SVH

// frame geometry: thirteen bytes, least significant bit first
`define SCM_FRAME_BITS      104
`define SCM_FRAME_BYTES     13
`define SCM_BITCNT_W        7

// wait windows count the frame byte in units of 1024 reference clocks
`define SCM_WAIT_UNIT_LOG2  10
`define SCM_WAIT_CNT_W      18

// pulse number field: 8-bit value with two forced zero bits below it
`define SCM_PULSE_SHIFT     2
`define SCM_PULSE_CNT_W     10

// current code clamp floor (lowest reference step)
`define SCM_CUR_CODE_MIN    5'h0B

// register word indices on the wishbone port (address bits 7:2)
`define SCM_REG_CTRL        6'h00
`define SCM_REG_STATUS      6'h01
`define SCM_REG_CHAN        6'h02
`define SCM_REG_PULSE       6'h03

// control register fields and reset value
`define SCM_CTRL_ACCEPT_BIT 0
`define SCM_CTRL_INHIB_BIT  1
`define SCM_CTRL_RESET      2'h1

`endif

// ===== pkg/scm_pkg.sv
// types shared by the stepper channel monitor modules
package scm_pkg;

  // fourth frame byte: power save (active low) and monitor select
  typedef struct packed {
    logic       ps_n;
    logic [6:0] sel;
  } scm_mon_cfg_t;

  // fifth frame byte: first channel settings
  typedef struct packed {
    logic       enable;
    logic       reverse_direction;
    logic       unused;
    logic [4:0] code;
  } scm_chan_cfg_t;

  // whole frame, first received byte in the low bits
  typedef struct packed {
    logic [7:0]    checksum;
    logic [31:0]   beta_bytes;
    logic [7:0]    period_hi;
    logic [7:0]    period_lo;
    logic [7:0]    pulse_num;
    scm_chan_cfg_t chan_a;
    scm_mon_cfg_t  mon;
    logic [7:0]    chop_cfg;
    logic [7:0]    magnet_wait;
    logic [7:0]    start_wait;
  } scm_frame_t;

  // start-delay / magnetize-delay sequencer
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_START, SEQ_MAGNET} scm_seq_t;

endpackage

// ===== rtl/scm_frame_rx.sv
// serial frame shifter with length and checksum check
`timescale 1ns/10ps
`default_nettype none
`include "scm_map.svh"
module scm_frame_rx
  import scm_pkg::*;
(
  // clock and reset
  input  wire logic  clk_i,
  input  wire logic  rst_n_i,
  // serial bits and latch strobe
  input  wire logic  bit_stb_i,
  input  wire logic  bit_val_i,
  input  wire logic  latch_stb_i,
  // received frame
  output scm_frame_t frame_o,
  output logic       done_o,
  output logic       good_o
);
  logic [`SCM_FRAME_BITS-1:0] shift_reg;  // shift register, first bit ends lowest
  logic [`SCM_BITCNT_W-1:0]   cnt_reg;    // received bits, saturating
  logic [7:0]                 sum;        // modulo-256 byte sum

  // sum of all thirteen bytes
  always_comb
  begin
    sum = 8'h00;
    for (int i = 0; i < `SCM_FRAME_BYTES; i++)
      sum = sum + shift_reg[i*8 +: 8];
  end

  // shift in bits and judge the frame at the latch strobe
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      shift_reg <= '0;
      cnt_reg   <= '0;
      done_o    <= 1'b0;
      good_o    <= 1'b0;
      frame_o   <= '0;
    end
    else
    begin
      done_o <= latch_stb_i;
      if (latch_stb_i)
      begin
        // a short or long frame is judged bad data
        good_o  <= (cnt_reg == `SCM_BITCNT_W'(`SCM_FRAME_BITS)) && (sum == 8'h00);
        frame_o <= shift_reg;
        cnt_reg <= '0;
      end
      else if (bit_stb_i)
      begin
        shift_reg <= {bit_val_i, shift_reg[`SCM_FRAME_BITS-1:1]};
        if (cnt_reg != '1)
          cnt_reg <= cnt_reg + `SCM_BITCNT_W'(1);
      end
    end
  end
endmodule
`default_nettype wire

// ===== rtl/scm_pulse_gen.sv
// pulse train generator counting periods in reference clock ticks
`timescale 1ns/10ps
`default_nettype none
`include "scm_map.svh"
module scm_pulse_gen
  import scm_pkg::*;
(
  // clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        rst_n_i,
  // reference tick, start and stop
  input  wire logic                        ref_tick_i,
  input  wire logic                        start_i,
  input  wire logic                        abort_i,
  // programmed count and period
  input  wire logic [`SCM_PULSE_CNT_W-1:0] count_i,
  input  wire logic [15:0]                 period_i,
  // pulse and gate
  output logic                             pulse_o,
  output logic                             gate_o
);
  logic [`SCM_PULSE_CNT_W-1:0] left_reg;  // pulses still to send
  logic [15:0]                 per_reg;   // ticks since last pulse

  // count ticks per period and pulses per run
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || abort_i)
    begin
      left_reg <= '0;
      per_reg  <= '0;
      gate_o   <= 1'b0;
      pulse_o  <= 1'b0;
    end
    else
    begin
      pulse_o <= 1'b0;
      if (start_i)
      begin
        left_reg <= count_i;
        per_reg  <= '0;
        gate_o   <= (count_i != '0);
      end
      else if (gate_o && ref_tick_i)
      begin
        // period zero behaves as one tick
        if (per_reg + 16'h0001 >= period_i)
        begin
          per_reg  <= '0;
          pulse_o  <= 1'b1;
          left_reg <= left_reg - `SCM_PULSE_CNT_W'(1);
          gate_o   <= (left_reg != `SCM_PULSE_CNT_W'(1));
        end
        else
          per_reg <= per_reg + 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

// ===== rtl/scm_top.sv
// stepper channel configuration decode, sequencing and monitor multiplexer
//
// Summary of operation
// - monitor pin is OR of selected sources
// - enable source high when outputs conduct
// - direction source high for reverse rotation
// - pulse-present high when frame carries pulses
// - pulse gate high while pulses generated
// - combined wait high over both delays
// - start-delay source high during start delay
// - checksum source high for good frame
// - chopping source shows internal chopping wave
// - fourth byte D7 zero selects power save
// - fifth byte: enable, direction, current code
// - enable zero floats outputs, counter still steps
// - direction zero forward, one reverse
// - codes up to 01010 clamp to lowest
// - pulse count is sixth byte times four
// - pulses start at combined window fall
// - 16-bit period in reference clocks
// - fourth byte D0-D6 select monitor sources
//
// Added by the designer: the register offsets and the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none
`include "scm_map.svh"
module scm_top
  import scm_pkg::*;
(
  // system clock and synchronous active-low reset
  input  wire logic        CLK_SYS_I,
  input  wire logic        RST_B_I,
  // classic wishbone slave
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  // serial frame pins and timing pins from the host
  input  wire logic        SER_CLK_I,
  input  wire logic        SER_DATA_I,
  input  wire logic        SER_LATCH_I,
  input  wire logic        FRAME_SYNC_I,
  input  wire logic        REF_CLK_I,
  // first channel drive controls
  output logic             MOTOR_OUT_EN_O,
  output logic             DIRECTION_O,
  output logic             STEP_PULSE_O,
  output logic      [5:0]  STEP_POS_O,
  output logic      [4:0]  CURRENT_REF_LEVEL_O,
  output logic             POWER_SAVE_O,
  // monitor pins
  output logic             MONITOR_OUT_A_O,
  output logic             MONITOR_OUT_B_O
);

  // ------------------------------------------------------------------
  // pin synchronisers and edge detection
  // ------------------------------------------------------------------
  logic [4:0] pin_raw;    // raw pins: ref, sync, latch, data, clk
  logic [4:0] meta_reg;   // first synchroniser stage
  logic [4:0] sync_reg;   // second synchroniser stage
  logic [4:0] prev_reg;   // previous synchronised value
  logic       ref_tick;   // reference clock rising edge
  logic       sync_rise;  // frame sync rising edge
  logic       latch_fall; // latch falling edge
  logic       bit_stb;    // serial clock rising edge

  assign pin_raw = {REF_CLK_I, FRAME_SYNC_I, SER_LATCH_I, SER_DATA_I, SER_CLK_I};

  // two flops per pin before any logic, then one for edges
  always_ff @(posedge CLK_SYS_I)
  begin
    if (!RST_B_I)
    begin
      meta_reg <= 5'h00;
      sync_reg <= 5'h00;
      prev_reg <= 5'h00;
    end
    else
    begin
      meta_reg <= pin_raw;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  // single-cycle enables from the synchronised pins
  assign bit_stb    = sync_reg[0] & ~prev_reg[0];
  assign latch_fall = ~sync_reg[2] & prev_reg[2];
  assign sync_rise  = sync_reg[3] & ~prev_reg[3];
  assign ref_tick   = sync_reg[4] & ~prev_reg[4];

  // ------------------------------------------------------------------
  // frame reception
  // ------------------------------------------------------------------
  scm_frame_t rx_frame;   // frame captured at latch
  logic       rx_done;    // one cycle after latch
  logic       rx_good;    // length and sum correct

  // bits shift in first byte first, lsb first
  scm_frame_rx u_rx
  (
    .clk_i       (CLK_SYS_I),
    .rst_n_i     (RST_B_I),
    .bit_stb_i   (bit_stb),
    .bit_val_i   (sync_reg[1]),
    .latch_stb_i (latch_fall),
    .frame_o     (rx_frame),
    .done_o      (rx_done),
    .good_o      (rx_good)
  );

  // ------------------------------------------------------------------
  // software control register
  // ------------------------------------------------------------------
  logic [1:0] ctrl_reg;     // accept enable, step inhibit
  logic       wb_req;       // access presented and not yet answered
  logic [5:0] wb_idx;       // word index of access

  assign wb_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  assign wb_idx = WB_ADR_I[7:2];

  // writes to the control word, low byte lane only
  always_ff @(posedge CLK_SYS_I)
  begin
    if (!RST_B_I)
      ctrl_reg <= `SCM_CTRL_RESET;
    else if (wb_req && WB_WE_I && WB_SEL_I[0] && (wb_idx == `SCM_REG_CTRL))
      ctrl_reg <= WB_DAT_I[1:0];
  end

  // ------------------------------------------------------------------
  // latched settings
  // ------------------------------------------------------------------
  scm_frame_t cfg_reg;          // settings in force
  logic       checksum_ok_reg;  // last frame judged good
  logic       pulse_present_flag;
  logic       accept;           // frame may replace settings

  // both wait bytes must be nonzero for a frame to latch
  assign accept = rx_good && ctrl_reg[`SCM_CTRL_ACCEPT_BIT]
                  && (rx_frame.start_wait != 8'h00) && (rx_frame.magnet_wait != 8'h00);

  // checksum flag follows every latched frame
  always_ff @(posedge CLK_SYS_I)
  begin
    if (!RST_B_I)
      checksum_ok_reg <= 1'b0;
    else if (rx_done)
      checksum_ok_reg <= rx_good;
  end

  // keep old settings until a good frame latches
  always_ff @(posedge CLK_SYS_I)
  begin
    if (!RST_B_I)
      cfg_reg <= '0;
    else if (rx_done && accept)
      cfg_reg <= rx_frame;
  end

  // pulse-present set at the latch of an accepted frame, held until the next accepted frame
  always_ff @(posedge CLK_SYS_I)
  begin
    if (!RST_B_I)
      pulse_present_flag <= 1'b0;
    else if (rx_done && accept)
      pulse_present_flag <= (rx_frame.pulse_num != 8'h00);
  end

  // ------------------------------------------------------------------
  // decoded settings
  // ------------------------------------------------------------------
  logic                        power_save;        // reduced-current state
  logic                        chan_enable;       // outputs conduct
  logic                        reverse_direction; // reverse rotation set
  logic [4:0]                  current_reference_level;
  logic [`SCM_PULSE_CNT_W-1:0] pulse_count;       // pulses per frame period
  logic [15:0]                 pulse_period;      // reference clocks per pulse

  // power save when the bit is zero
  assign power_save = ~cfg_reg.mon.ps_n;
  // enable bit, forced low in power save
  assign chan_enable = cfg_reg.chan_a.enable & ~power_save;
  assign reverse_direction = cfg_reg.chan_a.reverse_direction;
  // low codes clamp to the lowest step
  assign current_reference_level = (cfg_reg.chan_a.code < `SCM_CUR_CODE_MIN) ?
                                   `SCM_CUR_CODE_MIN : cfg_reg.chan_a.code;
  // byte times four, low bits zero
  assign pulse_count = {cfg_reg.pulse_num, `SCM_PULSE_SHIFT'(0)};
  // period low byte then high byte
  assign pulse_period = {cfg_reg.period_hi, cfg_reg.period_lo};

  // ------------------------------------------------------------------
  // start-delay and magnetize-delay sequencer
  // ------------------------------------------------------------------
  scm_seq_t                   seq_reg;     // current window
  logic [`SCM_WAIT_CNT_W-1:0] wait_reg;    // reference ticks left
  logic                       run_start;   // combined window has fallen
  logic                       start_delay_window;
  logic                       combined_wait_window;

  // windows counted in reference ticks from the frame sync edge
  always_ff @(posedge CLK_SYS_I)
  begin
    if (!RST_B_I || power_save)
    begin
      seq_reg   <= SEQ_IDLE;
      wait_reg  <= '0;
      run_start <= 1'b0;
    end
    else
    begin
      run_start <= 1'b0;
      if (sync_rise)
      begin
        // start delay opens at the sync edge
        seq_reg  <= SEQ_START;
        wait_reg <= {cfg_reg.start_wait, `SCM_WAIT_UNIT_LOG2'(0)};
      end
      else if (ref_tick)
      begin
        case (seq_reg)
          SEQ_START:
          begin
            if (wait_reg <= `SCM_WAIT_CNT_W'(1))
            begin
              seq_reg  <= SEQ_MAGNET;
              wait_reg <= {cfg_reg.magnet_wait, `SCM_WAIT_UNIT_LOG2'(0)};
            end
            else
              wait_reg <= wait_reg - `SCM_WAIT_CNT_W'(1);
          end
          SEQ_MAGNET:
          begin
            // pulses begin as the combined window falls
            if (wait_reg <= `SCM_WAIT_CNT_W'(1))
            begin
              seq_reg   <= SEQ_IDLE;
              run_start <= 1'b1;
            end
            else
              wait_reg <= wait_reg - `SCM_WAIT_CNT_W'(1);
          end
          default:
            seq_reg <= SEQ_IDLE;
        endcase
      end
    end
  end

  // start delay only, held high in power save
  assign start_delay_window = (seq_reg == SEQ_START) | power_save;
  // both delays together, low in power save
  assign combined_wait_window = (seq_reg == SEQ_START) | (seq_reg == SEQ_MAGNET);

  // ------------------------------------------------------------------
  // pulse generation and step counter
  // ------------------------------------------------------------------
  logic       pulse_out;   // one pulse per period
  logic       pulse_gate;  // pulses in progress
  logic       pulse_stop;  // halt the train
  logic [5:0] step_reg;    // micro-step position

  // new sync, power save or software inhibit stop the train
  assign pulse_stop = sync_rise | power_save | ctrl_reg[`SCM_CTRL_INHIB_BIT];

  // periods counted on reference ticks, gate over the run
  scm_pulse_gen u_pulse
  (
    .clk_i      (CLK_SYS_I),
    .rst_n_i    (RST_B_I),
    .ref_tick_i (ref_tick),
    .start_i    (run_start & checksum_ok_reg),
    .abort_i    (pulse_stop),
    .count_i    (pulse_count),
    .period_i   (pulse_period),
    .pulse_o    (pulse_out),
    .gate_o     (pulse_gate)
  );

  // counter steps even while outputs float
  always_ff @(posedge CLK_SYS_I)
  begin
    if (!RST_B_I)
      step_reg <= 6'h00;
    else if (pulse_out)
      step_reg <= reverse_direction ? step_reg - 6'h01 : step_reg + 6'h01;
  end

  // ------------------------------------------------------------------
  // chopping waveform
  // ------------------------------------------------------------------
  logic [5:0] chop_cnt_reg;  // ticks in current half wave
  logic       chop_reg;      // chopping wave level

  // code zero or power save stops the wave
  always_ff @(posedge CLK_SYS_I)
  begin
    if (!RST_B_I || power_save || (cfg_reg.chop_cfg[5:0] == 6'h00))
    begin
      chop_cnt_reg <= 6'h00;
      chop_reg     <= 1'b0;
    end
    else if (ref_tick)
    begin
      if (chop_cnt_reg + 6'h01 >= cfg_reg.chop_cfg[5:0])
      begin
        chop_cnt_reg <= 6'h00;
        chop_reg     <= ~chop_reg;
      end
      else
        chop_cnt_reg <= chop_cnt_reg + 6'h01;
    end
  end

  // ------------------------------------------------------------------
  // monitor multiplexer
  // ------------------------------------------------------------------
  logic [6:0] src_a;  // first channel sources, bit order D6..D0
  logic [6:0] src_b;  // second pin sources, second channel absent

  assign src_a = {chan_enable, reverse_direction, pulse_out, pulse_present_flag,
                  pulse_gate, checksum_ok_reg, chop_reg};
  assign src_b = {5'h00, combined_wait_window, start_delay_window};

  // selected sources ORed onto each pin
  always_ff @(posedge CLK_SYS_I)
  begin
    if (!RST_B_I)
    begin
      MONITOR_OUT_A_O <= 1'b0;
      MONITOR_OUT_B_O <= 1'b0;
    end
    else
    begin
      MONITOR_OUT_A_O <= |(cfg_reg.mon.sel & src_a);
      MONITOR_OUT_B_O <= |(cfg_reg.mon.sel & src_b);
    end
  end

  // drive outputs from flops
  always_ff @(posedge CLK_SYS_I)
  begin
    if (!RST_B_I)
    begin
      MOTOR_OUT_EN_O      <= 1'b0;
      DIRECTION_O         <= 1'b0;
      STEP_PULSE_O        <= 1'b0;
      CURRENT_REF_LEVEL_O <= `SCM_CUR_CODE_MIN;
      POWER_SAVE_O        <= 1'b1;
    end
    else
    begin
      MOTOR_OUT_EN_O      <= chan_enable;
      DIRECTION_O         <= reverse_direction;
      STEP_PULSE_O        <= pulse_out;
      CURRENT_REF_LEVEL_O <= current_reference_level;
      POWER_SAVE_O        <= power_save;
    end
  end

  assign STEP_POS_O = step_reg;

  // ------------------------------------------------------------------
  // wishbone answer
  // ------------------------------------------------------------------
  // one wait cycle, ack drops the cycle after, unmapped reads zero
  always_ff @(posedge CLK_SYS_I)
  begin
    if (!RST_B_I)
    begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end
    else
    begin
      WB_ACK_O <= wb_req;
      if (wb_req)
      begin
        case (wb_idx)
          `SCM_REG_CTRL:
            WB_DAT_O <= {30'h0000_0000, ctrl_reg};
          `SCM_REG_STATUS:
            WB_DAT_O <= {10'h000, step_reg, 10'h000, power_save, pulse_present_flag,
                         pulse_gate, combined_wait_window, start_delay_window,
                         checksum_ok_reg};
          `SCM_REG_CHAN:
            WB_DAT_O <= {16'h0000, cfg_reg.mon, cfg_reg.chan_a};
          `SCM_REG_PULSE:
            WB_DAT_O <= {pulse_period, 6'h00, pulse_count};
          default:
            WB_DAT_O <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// ===== dv/scm_top_sva.sv
// assertion checker for the stepper channel monitor top
`timescale 1ns/10ps
`default_nettype none
module scm_top_sva
(
  // clock and reset
  input wire logic       CLK_SYS_I,
  input wire logic       RST_B_I,
  // bus and latch pins
  input wire logic       WB_CYC_I,
  input wire logic       WB_STB_I,
  input wire logic       WB_ACK_O,
  input wire logic       SER_LATCH_I,
  // channel outputs
  input wire logic       MOTOR_OUT_EN_O,
  input wire logic       DIRECTION_O,
  input wire logic       STEP_PULSE_O,
  input wire logic [5:0] STEP_POS_O,
  input wire logic [4:0] CURRENT_REF_LEVEL_O,
  input wire logic       POWER_SAVE_O
);
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RST_B_I);
  logic [3:0] lat_cnt_reg; // cycles since latch fall, saturating
  // latch age, so settings changes can be tied to a latch
  always_ff @(posedge CLK_SYS_I)
  begin
    if (!RST_B_I)
      lat_cnt_reg <= 4'hF;
    else if (!SER_LATCH_I && $past(SER_LATCH_I))
      lat_cnt_reg <= 4'h0;
    else if (lat_cnt_reg != 4'hF)
      lat_cnt_reg <= lat_cnt_reg + 4'h1;
  end
  ack_latency_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("ack missing after request");
  ack_single_a: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I))
    else $error("ack without request");
  save_off_a: assert property (POWER_SAVE_O && $past(POWER_SAVE_O) |-> !MOTOR_OUT_EN_O)
    else $error("outputs conduct in power save");
  cur_floor_a: assert property (CURRENT_REF_LEVEL_O >= 5'h0B)
    else $error("current code below floor");
  step_gap_a: assert property (STEP_PULSE_O |=> !STEP_PULSE_O [*8])
    else $error("steps closer than one reference period");
  step_dir_a: assert property ($changed(STEP_POS_O) |->
    STEP_POS_O == $past(STEP_POS_O) + (DIRECTION_O ? 6'h3F : 6'h01))
    else $error("step position moved the wrong way");
  cfg_hold_a: assert property (
    $changed({DIRECTION_O, CURRENT_REF_LEVEL_O, MOTOR_OUT_EN_O}) |-> lat_cnt_reg < 4'hC)
    else $error("settings changed without a latch");
  cover property (STEP_PULSE_O);
  cover property (WB_ACK_O);
  cover property (lat_cnt_reg == 4'h0);
endmodule
bind scm_top scm_top_sva u_sva (.CLK_SYS_I(CLK_SYS_I), .RST_B_I(RST_B_I),
  .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O), .SER_LATCH_I(SER_LATCH_I),
  .MOTOR_OUT_EN_O(MOTOR_OUT_EN_O), .DIRECTION_O(DIRECTION_O), .STEP_PULSE_O(STEP_PULSE_O),
  .STEP_POS_O(STEP_POS_O), .CURRENT_REF_LEVEL_O(CURRENT_REF_LEVEL_O),
  .POWER_SAVE_O(POWER_SAVE_O));
`default_nettype wire

// ===== dv/scm_host_model.sv
// host controller model: serial frames, frame sync and reference clock
`timescale 1ns/10ps
`default_nettype none
module scm_host_model
(
  // system clock
  input  wire logic clk_i,
  // pins toward the device
  output var logic  ser_clk_o,
  output var logic  ser_data_o,
  output var logic  latch_o,
  output var logic  sync_o,
  output var logic  ref_clk_o
);
  logic [2:0] ref_cnt; // half period counter
  initial
  begin
    {ser_clk_o, ser_data_o, latch_o, sync_o, ref_clk_o} = 5'h00;
    ref_cnt = 3'h0;
  end
  // free running reference, 11 system cycles a period
  always @(posedge clk_i)
  begin
    if (ref_cnt == {2'b10, ref_clk_o})
    begin
      ref_clk_o <= ~ref_clk_o;
      ref_cnt <= 3'h0;
    end
    else
      ref_cnt <= ref_cnt + 3'h1;
  end
  task automatic send(input logic [95:0] b, input logic bad);
    logic [103:0] f;
    logic [7:0]   s;
    s = 8'h00;
    for (int i = 0; i < 12; i++)
      s = s + b[i*8 +: 8];
    f = {(8'h00 - s) ^ {7'h00, bad}, b};
    for (int i = 0; i < 104; i++)
    begin
      ser_data_o <= f[i];
      repeat (2) @(posedge clk_i);
      ser_clk_o <= 1'b1;
      repeat (3) @(posedge clk_i);
      ser_clk_o <= 1'b0;
      @(posedge clk_i);
    end
    ser_data_o <= ~f[103];
    latch_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    latch_o <= 1'b0;
  endtask
  // frame sync pulse starts the wait windows
  task automatic pulse_sync();
    sync_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    sync_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== dv/scm_top_bench.sv
// self-checking bench for the stepper channel monitor
`timescale 1ns/10ps
`default_nettype none
module scm_top_bench
  import scm_pkg::*;
;
  logic        clk = 1'b0, rst_b = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat = 32'h0, q, rdat;
  logic        sclk, sdat, lat, sync, rclk, en, dir, stp, ps, ma, mb, ack;
  logic [5:0]  pos;
  logic [4:0]  cur;
  int          fail_count = 0, comparisons = 0, n, k;
  always #10 clk = ~clk;
  scm_host_model host (.clk_i(clk), .ser_clk_o(sclk), .ser_data_o(sdat), .latch_o(lat),
    .sync_o(sync), .ref_clk_o(rclk));
  scm_top uut (.CLK_SYS_I(clk), .RST_B_I(rst_b), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(rdat),
    .WB_ACK_O(ack), .SER_CLK_I(sclk), .SER_DATA_I(sdat), .SER_LATCH_I(lat),
    .FRAME_SYNC_I(sync), .REF_CLK_I(rclk), .MOTOR_OUT_EN_O(en), .DIRECTION_O(dir),
    .STEP_PULSE_O(stp), .STEP_POS_O(pos), .CURRENT_REF_LEVEL_O(cur),
    .POWER_SAVE_O(ps), .MONITOR_OUT_A_O(ma), .MONITOR_OUT_B_O(mb));
  // verdict and end of run
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one classic wishbone access, read data left in q
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    dat <= d;
    n = 0;
    do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 40);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
    if (n >= 40)
    begin
      fail_count++;
      final_report();
    end
  endtask
  // frame with waits 1, period 3, one pulse group
  task automatic frame(input logic [7:0] m, input logic [7:0] c, input logic bad);
    host.send({40'h0, 8'h03, 8'h01, c, m, 8'h00, 8'h01, 8'h01}, bad);
    repeat (12) @(posedge clk);
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    chk("cur", 32'h0B, cur);
    chk("ps", 32'h1, ps);
    wb(8'h00, 1'b0, 32'h0);
    chk("ctrl", 32'h1, q);
    wb(8'h20, 1'b0, 32'h0);
    chk("unmapped", 32'h0, q);
    $display("reset test done");
    frame(8'hC3, 8'hC3, 1'b0);
    chk("cur", 32'h0B, cur);
    chk("dir", 32'h1, dir);
    chk("en", 32'h1, en);
    chk("mon_a", 32'h1, ma);
    wb(8'h08, 1'b0, 32'h0);
    chk("chan", 32'hC3C3, q);
    wb(8'h0C, 1'b0, 32'h0);
    chk("pulse", 32'h0003_0004, q);
    wb(8'h04, 1'b0, 32'h0);
    chk("sum_ok", 32'h1, {31'h0, q[0]});
    host.pulse_sync();
    k = 0;
    for (int i = 0; i < 30000; i++)
    begin
      @(posedge clk);
      k += (stp === 1'b1);
      if (stp === 1'b1 && k == 1)
      begin
        wb(8'h04, 1'b0, 32'h0);
        chk("gate", 32'h19, {26'h0, q[5:0]});
      end
      if (i == 200)
      begin
        chk("mon_b", 32'h1, mb);
        wb(8'h04, 1'b0, 32'h0);
        chk("waits", 32'h17, {26'h0, q[5:0]});
      end
    end
    chk("steps", 32'h4, k);
    chk("pos", 32'h3C, pos);
    chk("mon_b", 32'h0, mb);
    wb(8'h04, 1'b0, 32'h0);
    chk("status", 32'h003C_0011, q);
    $display("sequence test done");
    frame(8'hC3, 8'h1F, 1'b1);
    chk("cur", 32'h0B, cur);
    wb(8'h04, 1'b0, 32'h0);
    chk("sum_ok", 32'h0, {31'h0, q[0]});
    wb(8'h00, 1'b1, 32'h0);
    frame(8'hA2, 8'h1F, 1'b0);
    chk("cur", 32'h0B, cur);
    wb(8'h00, 1'b1, 32'h1);
    frame(8'hA2, 8'h1F, 1'b0);
    chk("cur", 32'h1F, cur);
    chk("dir", 32'h0, dir);
    chk("en", 32'h0, en);
    chk("mon_a", 32'h1, ma);
    frame(8'h00, 8'h1F, 1'b0);
    chk("ps", 32'h1, ps);
    chk("mon_a", 32'h0, ma);
    $display("frame test done");
    final_report();
  end
endmodule
`default_nettype wire
